//--- design/ppo_pkg.sv
package ppo_pkg;
  // pin, group and trigger channel counts
  localparam int PPO_PINS = 16;
  localparam int PPO_GROUPS = 4;
  localparam int PPO_CHANS = 4;
  localparam int PPO_GRP_BITS = 4;
  // register indices of the pattern unit on its own register port
  localparam logic [2:0] PPO_IDX_OE = 3'h0;
  localparam logic [2:0] PPO_IDX_STAGED = 3'h1;
  localparam logic [2:0] PPO_IDX_ODR = 3'h2;
  localparam logic [2:0] PPO_IDX_TSEL = 3'h3;
  localparam logic [2:0] PPO_IDX_MODE = 3'h4;
  // values after reset
  localparam logic [15:0] PPO_RST_OE = 16'h0000;
  localparam logic [15:0] PPO_RST_STAGED = 16'h0000;
  localparam logic [15:0] PPO_RST_ODR = 16'h0000;
  localparam logic [7:0] PPO_RST_TSEL = 8'h00;
  localparam logic [7:0] PPO_RST_MODE = 8'hF0;
  // output mode layout: direct selects in [7:4], non-overlap in [3:0]
  localparam int PPO_MODE_DIRECT_LSB = 4;
  localparam int PPO_MODE_NOV_LSB = 0;
  // controller apb offsets
  localparam logic [7:0] PPO_APB_CTRL = 8'h00;
  localparam logic [7:0] PPO_APB_CYCLE = 8'h04;
  localparam logic [7:0] PPO_APB_MARGIN = 8'h08;
  localparam logic [7:0] PPO_APB_PATTERN = 8'h0C;
  localparam logic [7:0] PPO_APB_STATUS = 8'h10;
  // controller ctrl bits
  localparam int PPO_CTRL_RUN = 0;
  localparam int PPO_CTRL_NOV = 1;
  localparam int PPO_CTRL_AWAKE = 2;
  localparam int PPO_CTRL_CAPT = 3;
  // controller reset values
  localparam logic [3:0] PPO_RST_CTRL = 4'h0;
  localparam logic [15:0] PPO_RST_CYCLE = 16'h00FF;
  localparam logic [15:0] PPO_RST_MARGIN = 16'h0010;
  localparam logic [7:0] PPO_RST_PATTERN = 8'h00;
  // configuration the controller writes into the pattern unit
  localparam logic [15:0] PPO_CFG_OE = 16'hFF00;
  localparam logic [7:0] PPO_CFG_TSEL = 8'h00;
  localparam logic [7:0] PPO_CFG_MODE_NORMAL = 8'hF0;
  localparam logic [7:0] PPO_CFG_MODE_NOV = 8'hFC;
  // controller sequence, gray coded along the usual path
  typedef enum logic [2:0] {
    PPO_ST_IDLE = 3'b000,
    PPO_ST_W_OE = 3'b001,
    PPO_ST_W_SEL = 3'b011,
    PPO_ST_W_MODE = 3'b010,
    PPO_ST_W_DATA = 3'b110,
    PPO_ST_RUN = 3'b111,
    PPO_ST_REFILL = 3'b101
  } ppo_state_t;
endpackage

//--- design/ppo_if.sv
`timescale 1ns/10ps
interface ppo_if;
  import ppo_pkg::*;
  logic reg_req; // access request, held until reg_ack
  logic reg_wr; // 1 write, 0 read
  logic [2:0] reg_addr; // register index
  logic [15:0] reg_wdata; // write data
  logic reg_ack; // one-cycle answer
  logic [15:0] reg_rdata; // read data, valid with reg_ack
  logic mstop; // module stop request, high halts the unit
  logic [PPO_CHANS-1:0] cmp_a; // compare match a pulses per channel
  logic [PPO_CHANS-1:0] cmp_b; // compare match b pulses per channel
  logic [PPO_CHANS-1:0] cap_a; // input capture a pulses per channel
  logic [PPO_CHANS-1:0] a_capture; // compare a register works as capture
  modport dev (
    input reg_req, reg_wr, reg_addr, reg_wdata, mstop, cmp_a, cmp_b, cap_a, a_capture,
    output reg_ack, reg_rdata
  );
  modport host (
    output reg_req, reg_wr, reg_addr, reg_wdata, mstop, cmp_a, cmp_b, cap_a, a_capture,
    input reg_ack, reg_rdata
  );
endinterface

//--- design/ppo_timer.sv
`timescale 1ns/10ps
module ppo_timer
  import ppo_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [15:0] cycle_in,
  input wire logic [15:0] margin_in,
  output logic cmp_a_out,
  output logic cmp_b_out
);
  logic [15:0] cnt_q; // free counter of the trigger channel
  logic [15:0] cnt_d;
  logic cmp_a_q; // registered match pulses
  logic cmp_a_d;
  logic cmp_b_q;
  logic cmp_b_d;

  // cycle sits in compare b, margin in compare a, clear on match b
  always_comb begin
    cnt_d = 16'h0000;
    cmp_a_d = 1'b0;
    cmp_b_d = 1'b0;
    if (run_in) begin
      cmp_a_d = (cnt_q == margin_in);
      cmp_b_d = (cnt_q == cycle_in);
      // clearing on match b makes b the period end, a the margin after it
      cnt_d = (cnt_q == cycle_in) ? 16'h0000 : 16'(cnt_q + 16'h0001);
    end
  end

  // registers only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= 16'h0000;
      cmp_a_q <= 1'b0;
      cmp_b_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
    end
  end

  assign cmp_a_out = cmp_a_q;
  assign cmp_b_out = cmp_b_q;
endmodule

//--- design/ppo_host.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module ppo_host
  import ppo_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cap_event_in,
  ppo_if.host link
);
  ppo_state_t st_q; // configuration and refill sequence
  ppo_state_t st_d;
  logic [3:0] ctrl_q; // run, nov, awake, capture mode
  logic [3:0] ctrl_d;
  logic [15:0] cycle_q; // period for compare b
  logic [15:0] cycle_d;
  logic [15:0] margin_q; // non-overlap margin for compare a
  logic [15:0] margin_d;
  logic [7:0] pat_q; // next pattern from software
  logic [7:0] pat_d;
  logic pend_q; // pattern waiting to be sent
  logic pend_d;
  logic [7:0] refills_q; // count of refills sent
  logic [7:0] refills_d;
  logic [31:0] rdata_q; // apb read data, loaded in setup
  logic [31:0] rdata_d;
  logic [1:0] cap_sync_q; // capture pin synchroniser
  logic cap_prev_q; // last synchronised capture level
  logic running; // timer allowed to count
  logic cmp_a;
  logic cmp_b;
  logic apb_wr;
  logic apb_hit;

  assign running = (st_q == PPO_ST_RUN) || (st_q == PPO_ST_REFILL);

  ppo_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(running),
    .cycle_in(cycle_q),
    .margin_in(margin_q),
    .cmp_a_out(cmp_a),
    .cmp_b_out(cmp_b)
  );

  // apb decode; every access finishes in its first access cycle
  assign apb_hit = (paddr_in == PPO_APB_CTRL) || (paddr_in == PPO_APB_CYCLE) ||
                   (paddr_in == PPO_APB_MARGIN) || (paddr_in == PPO_APB_PATTERN) ||
                   (paddr_in == PPO_APB_STATUS);
  assign apb_wr = psel_in && penable_in && pwrite_in && apb_hit;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !apb_hit;
  assign prdata_out = rdata_q;

  // controller trigger channel 0 only; the rest stay quiet
  assign link.cmp_a = {3'b000, cmp_a};
  assign link.cmp_b = {3'b000, cmp_b};
  assign link.cap_a = {3'b000, cap_sync_q[1] && !cap_prev_q};
  assign link.a_capture = {3'b000, ctrl_q[PPO_CTRL_CAPT]};
  assign link.mstop = !ctrl_q[PPO_CTRL_AWAKE];

  // register port requests follow the sequence state
  always_comb begin
    link.reg_req = 1'b1;
    link.reg_wr = 1'b1;
    link.reg_addr = PPO_IDX_OE;
    link.reg_wdata = PPO_CFG_OE;
    case (st_q)
      PPO_ST_W_OE: begin
      end
      PPO_ST_W_SEL: begin
        link.reg_addr = PPO_IDX_TSEL;
        link.reg_wdata = {8'h00, PPO_CFG_TSEL};
      end
      PPO_ST_W_MODE: begin
        link.reg_addr = PPO_IDX_MODE;
        link.reg_wdata = {8'h00, ctrl_q[PPO_CTRL_NOV] ? PPO_CFG_MODE_NOV
                                                      : PPO_CFG_MODE_NORMAL};
      end
      PPO_ST_W_DATA, PPO_ST_REFILL: begin
        link.reg_addr = PPO_IDX_STAGED;
        link.reg_wdata = {pat_q, 8'h00};
      end
      default: begin
        link.reg_req = 1'b0;
        link.reg_wr = 1'b0;
      end
    endcase
  end

  // sequence and software registers
  always_comb begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    cycle_d = cycle_q;
    margin_d = margin_q;
    pat_d = pat_q;
    pend_d = pend_q;
    refills_d = refills_q;
    rdata_d = rdata_q;
    case (st_q)
      PPO_ST_IDLE: begin
        if (ctrl_q[PPO_CTRL_RUN]) begin
          st_d = PPO_ST_W_OE;
        end
      end
      PPO_ST_W_OE: begin
        if (link.reg_ack) begin
          st_d = PPO_ST_W_SEL;
        end
      end
      PPO_ST_W_SEL: begin
        if (link.reg_ack) begin
          st_d = PPO_ST_W_MODE;
        end
      end
      PPO_ST_W_MODE: begin
        if (link.reg_ack) begin
          st_d = PPO_ST_W_DATA;
        end
      end
      PPO_ST_W_DATA: begin
        if (link.reg_ack) begin
          st_d = PPO_ST_RUN;
          pend_d = 1'b0;
        end
      end
      PPO_ST_RUN: begin
        if (!ctrl_q[PPO_CTRL_RUN]) begin
          st_d = PPO_ST_IDLE;
        end else if (cmp_a && pend_q) begin
          // refill on a compare a while a pattern is pending, well before the next match b
          st_d = PPO_ST_REFILL;
        end
      end
      PPO_ST_REFILL: begin
        // this refill path stands in for a transfer engine woken by compare a
        if (link.reg_ack) begin
          st_d = PPO_ST_RUN;
          pend_d = 1'b0;
          refills_d = 8'(refills_q + 8'h01);
        end
      end
      default: st_d = PPO_ST_IDLE;
    endcase
    if (apb_wr) begin
      case (paddr_in)
        PPO_APB_CTRL: ctrl_d = pwdata_in[3:0];
        PPO_APB_CYCLE: cycle_d = pwdata_in[15:0];
        PPO_APB_MARGIN: margin_d = pwdata_in[15:0];
        PPO_APB_PATTERN: begin
          pat_d = pwdata_in[7:0];
          pend_d = 1'b1; // a new pattern wins over the clear
        end
        default: begin
        end
      endcase
    end
    if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        PPO_APB_CTRL: rdata_d = {28'h0000000, ctrl_q};
        PPO_APB_CYCLE: rdata_d = {16'h0000, cycle_q};
        PPO_APB_MARGIN: rdata_d = {16'h0000, margin_q};
        PPO_APB_PATTERN: rdata_d = {24'h000000, pat_q};
        PPO_APB_STATUS: rdata_d = {16'h0000, refills_q, 5'h00, st_q == PPO_ST_IDLE,
                                   pend_q, running};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= PPO_ST_IDLE;
      ctrl_q <= PPO_RST_CTRL;
      cycle_q <= PPO_RST_CYCLE;
      margin_q <= PPO_RST_MARGIN;
      pat_q <= PPO_RST_PATTERN;
      pend_q <= 1'b0;
      refills_q <= 8'h00;
      rdata_q <= 32'h00000000;
      cap_sync_q <= 2'b00;
      cap_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      cycle_q <= cycle_d;
      margin_q <= margin_d;
      pat_q <= pat_d;
      pend_q <= pend_d;
      refills_q <= refills_d;
      rdata_q <= rdata_d;
      cap_sync_q <= {cap_sync_q[0], cap_event_in};
      cap_prev_q <= cap_sync_q[1];
    end
  end
endmodule

//--- design/ppo_device.sv
`timescale 1ns/10ps
module ppo_device
  import ppo_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  ppo_if.dev link,
  input wire logic [PPO_PINS-1:0] alt_en_in,
  input wire logic [PPO_PINS-1:0] alt_data_in,
  output logic [PPO_PINS-1:0] pin_out,
  output logic [PPO_PINS-1:0] pin_oe_n_out
);
  // software visible state
  logic [15:0] oe_q; // output enable per pin
  logic [15:0] oe_d;
  logic [15:0] stg_q; // staged next data
  logic [15:0] stg_d;
  logic [15:0] odr_q; // output data, what the pins follow
  logic [15:0] odr_d;
  logic [7:0] tsel_q; // two channel select bits per group
  logic [7:0] tsel_d;
  logic [7:0] mode_q; // direct selects and non-overlap bits
  logic [7:0] mode_d;
  // port and trigger state
  logic stop_q; // module stop, set from reset
  logic ack_q; // register port answer
  logic ack_d;
  logic [15:0] rdata_q; // read data, valid with the answer
  logic [15:0] rdata_d;
  logic [PPO_CHANS-1:0] prev_a_q; // last trigger a levels
  logic [PPO_CHANS-1:0] prev_b_q; // last match b levels
  logic [PPO_CHANS-1:0] trig_a; // match a or capture, per channel
  logic [PPO_CHANS-1:0] ev_a; // first cycle of a trigger a
  logic [PPO_CHANS-1:0] ev_b; // first cycle of a match b
  logic accept; // a request taken this cycle

  // picks the event of the channel a group listens to
  function automatic logic group_event(input logic [PPO_CHANS-1:0] ev,
                                       input logic [7:0] sel, input int grp);
    logic [1:0] ch;
    ch = sel[2*grp +: 2];
    return ev[ch];
  endfunction

  // read multiplexer of the register port
  function automatic logic [15:0] read_reg(input logic [2:0] idx, input logic [15:0] oe,
                                           input logic [15:0] stg, input logic [15:0] odr,
                                           input logic [7:0] tsel, input logic [7:0] mode);
    logic [15:0] val;
    val = 16'h0000;
    case (idx)
      PPO_IDX_OE: val = oe;
      PPO_IDX_STAGED: val = stg;
      PPO_IDX_ODR: val = odr;
      PPO_IDX_TSEL: val = {8'h00, tsel};
      PPO_IDX_MODE: val = {8'h00, mode};
      default: val = 16'h0000;
    endcase
    return val;
  endfunction

  // trigger a is the capture pulse when compare a acts as capture
  always_comb begin
    for (int c = 0; c < PPO_CHANS; c++) begin
      trig_a[c] = link.a_capture[c] ? link.cap_a[c] : link.cmp_a[c];
    end
  end

  // only a rising level counts, so a stretched pulse moves data once
  assign ev_a = trig_a & ~prev_a_q;
  assign ev_b = link.cmp_b & ~prev_b_q;

  // a request is taken once; the answer blocks a second take
  assign accept = link.reg_req && !ack_q;

  // register writes, reads and pattern transfers
  always_comb begin
    oe_d = oe_q;
    stg_d = stg_q;
    odr_d = odr_q;
    tsel_d = tsel_q;
    mode_d = mode_q;
    ack_d = accept;
    rdata_d = rdata_q;
    // stopped unit still answers, so a master never hangs, but ignores data
    if (accept && !stop_q) begin
      if (link.reg_wr) begin
        case (link.reg_addr)
          PPO_IDX_OE: oe_d = link.reg_wdata;
          PPO_IDX_STAGED: stg_d = link.reg_wdata;
          PPO_IDX_ODR: odr_d = link.reg_wdata; // preset start value
          PPO_IDX_TSEL: tsel_d = link.reg_wdata[7:0];
          PPO_IDX_MODE: mode_d = link.reg_wdata[7:0];
          default: begin
          end
        endcase
        rdata_d = 16'h0000;
      end else begin
        rdata_d = read_reg(link.reg_addr, oe_q, stg_q, odr_q, tsel_q, mode_q);
      end
    end else if (accept) begin
      rdata_d = 16'h0000;
    end
    // transfers come after the software write, so a trigger wins the bit
    if (!stop_q) begin
      for (int g = 0; g < PPO_GROUPS; g++) begin
        for (int b = 0; b < PPO_GRP_BITS; b++) begin
          // pin ownership is not looked at here on purpose
          if (oe_q[g*PPO_GRP_BITS + b]) begin
            if (group_event(ev_a, tsel_q, g)) begin
              // match a copies every bit, so rises happen only here
              odr_d[g*PPO_GRP_BITS + b] = stg_q[g*PPO_GRP_BITS + b];
            end else if (mode_q[PPO_MODE_NOV_LSB + g] && group_event(ev_b, tsel_q, g) &&
                         !stg_q[g*PPO_GRP_BITS + b]) begin
              // match b only takes staged zeros, lowering ones early
              odr_d[g*PPO_GRP_BITS + b] = 1'b0;
            end
          end
        end
      end
    end
  end

  // registers only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      oe_q <= PPO_RST_OE;
      stg_q <= PPO_RST_STAGED;
      odr_q <= PPO_RST_ODR;
      tsel_q <= PPO_RST_TSEL;
      mode_q <= PPO_RST_MODE;
      stop_q <= 1'b1;
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
      prev_a_q <= '0;
      prev_b_q <= '0;
    end else begin
      oe_q <= oe_d;
      stg_q <= stg_d;
      odr_q <= odr_d;
      tsel_q <= tsel_d;
      mode_q <= mode_d;
      stop_q <= link.mstop;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      prev_a_q <= trig_a;
      prev_b_q <= link.cmp_b;
    end
  end

  assign link.reg_ack = ack_q;
  assign link.reg_rdata = rdata_q;

  // pin drivers; inversion has no flop so a select change shows at once
  always_comb begin
    for (int i = 0; i < PPO_PINS; i++) begin
      if (alt_en_in[i]) begin
        // the other function owns the pin while enabled
        pin_out[i] = alt_data_in[i];
        pin_oe_n_out[i] = 1'b0;
      end else begin
        pin_out[i] = mode_q[PPO_MODE_DIRECT_LSB + i/PPO_GRP_BITS] ? odr_q[i]
                                                                   : !odr_q[i];
        pin_oe_n_out[i] = !(oe_q[i] && !stop_q);
      end
    end
  end
endmodule

//--- tb/ppo_props.sv
`timescale 1ns/10ps
// watches the register port and trigger lines between host and device
module ppo_props
  import ppo_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic mstop,
  input wire logic [PPO_CHANS-1:0] cmp_a,
  input wire logic [PPO_CHANS-1:0] cmp_b,
  input wire logic [PPO_CHANS-1:0] cap_a
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_ack_next_cycle: assert property (reg_req && !reg_ack |=> reg_ack)
    else $error("register request not answered next cycle");
  a_ack_one_cycle: assert property (reg_ack |=> !reg_ack)
    else $error("register answer longer than one cycle");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_req) && !$past(reg_ack))
    else $error("register answer without request");
  a_req_held: assert property (
    reg_req && !reg_ack |=> reg_req && $stable({reg_wr, reg_addr, reg_wdata}))
    else $error("register request changed before answer");
  // a mid-run reset may change read data, so skip the edge just after it
  a_rdata_kept: assert property (
    $past(rst_n_in) && !reg_ack |-> $stable(reg_rdata))
    else $error("read data moved without answer");
  a_cmpa_pulse: assert property (cmp_a[0] |=> !cmp_a[0])
    else $error("compare a longer than one cycle");
  a_cmpb_pulse: assert property (cmp_b[0] |=> !cmp_b[0])
    else $error("compare b longer than one cycle");
  a_cap_pulse: assert property (cap_a[0] |=> !cap_a[0])
    else $error("capture event longer than one cycle");
  a_spare_idle: assert property (
    cmp_a[PPO_CHANS-1:1] == '0 && cmp_b[PPO_CHANS-1:1] == '0 && cap_a[PPO_CHANS-1:1] == '0)
    else $error("unused channel event seen");
  a_stop_at_reset: assert property (!$past(rst_n_in) |-> mstop)
    else $error("unit not stopped after reset");
  // counter clears on b, so a cannot follow b at once with a real margin
  a_margin_gap: assert property (cmp_b[0] |=> !cmp_a[0])
    else $error("compare a right after compare b");
  c_write: cover property (reg_ack && reg_wr);
  c_read: cover property (reg_ack && !reg_wr);
  c_match_b: cover property (cmp_b[0]);
  c_capture: cover property (cap_a[0]);
endmodule

//--- tb/tb_pulse_pattern_output.sv
`timescale 1ns/10ps
module tb_pulse_pattern_output;
  import ppo_pkg::*;
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, cap_ev, err;
  logic [7:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rd; // apb data and last read
  logic [15:0] alt_en, alt_data, pins, oe_n; // shared pin side
  int num_errors, checked;
  ppo_if ppo_if_i();
  ppo_host ppo_host_i(.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cap_event_in(cap_ev), .link(ppo_if_i));
  ppo_device ppo_device_i(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(ppo_if_i),
    .alt_en_in(alt_en), .alt_data_in(alt_data), .pin_out(pins), .pin_oe_n_out(oe_n));
  ppo_props ppo_props_i(.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req(ppo_if_i.reg_req),
    .reg_wr(ppo_if_i.reg_wr), .reg_addr(ppo_if_i.reg_addr), .reg_wdata(ppo_if_i.reg_wdata),
    .reg_ack(ppo_if_i.reg_ack), .reg_rdata(ppo_if_i.reg_rdata), .mstop(ppo_if_i.mstop),
    .cmp_a(ppo_if_i.cmp_a), .cmp_b(ppo_if_i.cmp_b), .cap_a(ppo_if_i.cap_a));
  // 250 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t pins %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    num_errors++;
    $display("ERROR %0t wait ran out", $time);
    print_verdict();
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk32(rd, e);
    chk32({31'h0, err}, {31'h0, ee});
  endtask
  // wait for an event pulse (0 match a, 1 match b, 2 capture), then one edge more
  task automatic wait_ev(input int k);
    int n;
    logic hit;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
      hit = (k == 0) ? ppo_if_i.cmp_a[0] : (k == 1) ? ppo_if_i.cmp_b[0] : ppo_if_i.cap_a[0];
    end while (hit !== 1'b1 && n < 300);
    if (hit !== 1'b1) tmo();
    @(posedge clk_in);
  endtask
  // refill at one match a, then pins move at b (zeros only, with nov) and at a
  task automatic step(input logic [7:0] p, input logic [7:0] prev, input logic nov);
    apb(1'b1, PPO_APB_PATTERN, {24'h0, p});
    wait_ev(0);
    wait_ev(1);
    chk16(pins, {(nov ? (prev & p) : prev), 8'h00});
    wait_ev(0);
    chk16(pins, {p, 8'h00});
  endtask
  task automatic t_reset();
    chk16(pins, 16'h0000);
    chk16(oe_n, 16'hFFFF);
    rdchk(PPO_APB_CTRL, 32'h0, 1'b0);
    rdchk(PPO_APB_CYCLE, 32'h00FF, 1'b0);
    rdchk(PPO_APB_MARGIN, 32'h0010, 1'b0);
    rdchk(8'h14, 32'h0, 1'b1);
    apb(1'b1, PPO_APB_CYCLE, 32'h14);
    apb(1'b1, PPO_APB_MARGIN, 32'h05);
    rdchk(PPO_APB_CYCLE, 32'h14, 1'b0);
    // run without waking: setup writes are dropped
    apb(1'b1, PPO_APB_PATTERN, 32'hAA);
    apb(1'b1, PPO_APB_CTRL, 32'h1);
    wait_ev(0);
    wait_ev(0);
    chk16(oe_n, 16'hFFFF);
    chk16(pins, 16'h0000);
    apb(1'b1, PPO_APB_CTRL, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_normal();
    apb(1'b1, PPO_APB_PATTERN, 32'h80);
    apb(1'b1, PPO_APB_CTRL, 32'h5);
    wait_ev(0);
    chk16(pins, 16'h8000);
    chk16(oe_n, 16'h00FF);
    step(8'h40, 8'h80, 1'b0);
    // one refill sent, running, nothing pending
    rdchk(PPO_APB_STATUS, 32'h00000101, 1'b0);
    $display("test normal done");
  endtask
  task automatic t_nov();
    apb(1'b1, PPO_APB_CTRL, 32'h0);
    apb(1'b1, PPO_APB_PATTERN, 32'h95);
    apb(1'b1, PPO_APB_CTRL, 32'h7);
    wait_ev(0);
    chk16(pins, 16'h9500);
    step(8'h65, 8'h95, 1'b1);
    step(8'h59, 8'h65, 1'b1);
    step(8'h56, 8'h59, 1'b1);
    // four refills so far across both runs
    rdchk(PPO_APB_STATUS, 32'h00000401, 1'b0);
    $display("test nonoverlap done");
  endtask
  task automatic t_capture();
    apb(1'b1, PPO_APB_CTRL, 32'h0);
    apb(1'b1, PPO_APB_PATTERN, 32'h3C);
    // hand the top nibble to the other function while no trigger can come
    alt_en <= 16'hF000;
    alt_data <= 16'hA000;
    apb(1'b1, PPO_APB_CTRL, 32'hD);
    wait_ev(0);
    wait_ev(0);
    chk16(pins, 16'hA600);
    cap_ev <= 1'b1;
    wait_ev(2);
    chk16(pins, 16'hAC00);
    repeat (6) @(posedge clk_in);
    cap_ev <= 1'b0;
    chk16(pins, 16'hAC00);
    apb(1'b1, PPO_APB_CTRL, 32'h0);
    alt_en <= 16'h0000;
    @(posedge clk_in);
    @(posedge clk_in);
    chk16(pins, 16'h3C00);
    $display("test capture done");
  endtask
  // main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    rst_n_in <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    cap_ev <= 1'b0;
    alt_en <= 16'h0000;
    alt_data <= 16'h0000;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_normal();
    t_nov();
    t_capture();
    print_verdict();
  end
endmodule
